// [turns_device.sv]
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module turns_device #(
  parameter int PERIOD_W = 16
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // link to host
  turns_link_if.dev LINK,
  // angle sources, same clock
  input wire logic [11:0] FINE_ANGLE,
  input wire logic [11:0] COARSE_ANGLE,
  input wire logic ANGLE_STROBE,
  // static configuration
  input wire logic COUNT_PATH_SELECT,
  input wire logic MODE_180,
  input wire logic [1:0] TURNS_INIT,
  input wire logic [11:0] VELOCITY_THRESHOLD,
  input wire logic [PERIOD_W-1:0] SLEEP_PERIOD_SETTING,
  // power management
  input wire logic PLL_LOCKED,
  output logic PLL_ENABLE,
  output logic OUTPUTS_TRISTATE,
  output logic ANGLE_OUTPUT_VALID
);
  typedef struct packed {
    turns_pkg::lp_state_t st;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic sclk_d;
    logic [31:0] rx;
    logic [15:0] tx;
    logic [5:0] bitcnt;
    logic miso;
    logic miso_oe;
    logic [23:0] total;
    logic [11:0] held_lo;
    logic [11:0] last_ang;
    logic busy;
    logic ovf;
    logic warn;
    logic [15:0] alive;
    logic armed;
    logic [11:0] low_cnt;
    logic pll_en;
    logic tristate;
    logic out_valid;
  } dev_t;
  dev_t q;
  dev_t d;
  logic period_end;
  logic sclk_s;
  logic csn_s;
  logic mosi_s;
  logic rouse_s;
  logic all_low;
  logic sample;
  logic low_path;
  logic [11:0] src;
  logic signed [11:0] delta;
  logic [11:0] dmag;
  logic [24:0] sum;
  logic [12:0] rev_n;
  logic [12:0] rmax;
  logic [12:0] rmin;
  logic [15:0] rdata;
  logic [6:0] addr;

  // ==========================================================
  // slow interval timer
  sleep_timer #(.W(PERIOD_W)) u_timer (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .period(SLEEP_PERIOD_SETTING),
    .period_end(period_end)
  );

  // ==========================================================
  // synchronised pins, only the second stage is read
  assign sclk_s = q.sync2[0];
  assign csn_s = q.sync2[1];
  assign mosi_s = q.sync2[2];
  assign rouse_s = q.sync2[3];
  assign all_low = !sclk_s && !csn_s && !mosi_s;
  // at the half-frame point the write bit sits in rx[15] and the address just below it
  assign addr = q.rx[14:8];

  // read mux on the address just shifted in
  always_comb begin
    if (addr == turns_pkg::REG_TOTAL_HI) begin
      rdata = {4'h0, q.total[23:12]};
    end else if (addr == turns_pkg::REG_TOTAL_LO) begin
      rdata = {4'h0, q.held_lo};
    end else if (addr == turns_pkg::REG_ALIVE) begin
      rdata = q.alive;
    end else if (addr == turns_pkg::REG_FLAGS) begin
      rdata = {13'h0, q.armed, q.warn, q.ovf};
    end else begin
      rdata = 16'h0000;
    end
  end

  // ==========================================================
  // sample source, delta and saturating accumulation
  always_comb begin
    low_path = (q.st == turns_pkg::ST_WAKE) || (q.st == turns_pkg::ST_SLEEP);
    sample = 1'b0;
    if (q.st == turns_pkg::ST_FULL) begin
      sample = ANGLE_STROBE;
    end else if (q.st == turns_pkg::ST_WAKE) begin
      sample = period_end;
    end else if (q.st == turns_pkg::ST_SLEEP) begin
      sample = period_end || rouse_s;
    end
    // full path only when powered and selected
    src = (COUNT_PATH_SELECT && !low_path) ? FINE_ANGLE : COARSE_ANGLE;
    // 12-bit wrap makes a half turn or more count the other way
    delta = signed'(src - q.last_ang);
    dmag = delta[11] ? 12'(-delta) : 12'(delta);
    sum = {q.total[23], q.total} + {{13{delta[11]}}, delta};
    rev_n = sum[24:12];
    rmax = MODE_180 ? turns_pkg::REV180_MAX : turns_pkg::REV45_MAX;
    rmin = MODE_180 ? turns_pkg::REV180_MIN : turns_pkg::REV45_MIN;
  end

  // ==========================================================
  // main next-state process
  always_comb begin
    d = q;
    d.sync1 = {LINK.rouse, LINK.mosi, LINK.csn, LINK.sclk};
    d.sync2 = q.sync1;
    d.sclk_d = sclk_s;
    // pins-low timer for low-power entry
    if (all_low) begin
      if (q.low_cnt != turns_pkg::LP_ENTRY_CYCLES) begin
        d.low_cnt = q.low_cnt + 12'h001;
      end
    end else begin
      d.low_cnt = 12'h000;
    end
    // serial slave, mode 3; disabled while in low power
    if (csn_s || low_path) begin
      d.bitcnt = 6'h00;
      d.miso_oe = 1'b0;
    end else begin
      d.miso_oe = 1'b1;
      if (sclk_s && !q.sclk_d) begin
        d.rx = {q.rx[30:0], mosi_s};
        d.bitcnt = q.bitcnt + 6'h01;
      end
      if (!sclk_s && q.sclk_d) begin
        d.miso = q.tx[15];
        d.tx = {q.tx[14:0], 1'b0};
      end
      // address complete: fetch data for the second half
      if (q.bitcnt == turns_pkg::FRAME_HALF && d.bitcnt == q.bitcnt) begin
        d.bitcnt = q.bitcnt + 6'h01;
      end
    end
    if (q.bitcnt == turns_pkg::FRAME_HALF && !csn_s && !low_path) begin
      d.tx = rdata;
      if (!q.rx[15] && addr == turns_pkg::REG_TOTAL_HI) begin
        d.held_lo = q.total[11:0];
      end
    end
    // write takes effect at frame end
    if (csn_s && q.bitcnt == 6'h21 && q.rx[turns_pkg::FRAME_WR_BIT]
        && q.rx[30:24] == turns_pkg::REG_CTRL) begin
      if (q.rx[3:0] == turns_pkg::CMD_TURNS_RESET) begin
        d.total = turns_pkg::TOTAL_RST;
        d.ovf = 1'b0;
      end else if (q.rx[3:0] == turns_pkg::CMD_LP_ARM) begin
        d.armed = 1'b1;
      end else if (q.rx[3:0] == turns_pkg::CMD_FLAG_CLEAR) begin
        d.warn = 1'b0;
      end
    end
    // accumulate; a set here overrides any clear above
    if (sample) begin
      d.last_ang = src;
      d.busy = dmag >= VELOCITY_THRESHOLD;
      if ($signed(rev_n) > $signed(rmax)) begin
        d.total = {rmax[11:0], sum[11:0]};
        d.ovf = 1'b1;
      end else if ($signed(rev_n) < $signed(rmin)) begin
        d.total = {rmin[11:0], sum[11:0]};
        d.ovf = 1'b1;
      end else begin
        d.total = sum[23:0];
      end
      if (low_path && dmag > turns_pkg::WARN_DELTA) begin
        d.warn = 1'b1;
      end
    end
    // power state machine
    case (q.st)
      turns_pkg::ST_INIT: begin
        d.last_ang = src;
        if (TURNS_INIT == turns_pkg::INIT_ZERO) begin
          d.total = turns_pkg::TOTAL_RST;
        end else if (TURNS_INIT == turns_pkg::INIT_ANGLE) begin
          d.total = {{12{1'b0}}, src};
        end else begin
          d.total = {{12{1'b0}}, src};
        end
        d.pll_en = 1'b1;
        d.st = turns_pkg::ST_LOCK;
      end
      turns_pkg::ST_FULL: begin
        if (q.low_cnt == turns_pkg::LP_ENTRY_CYCLES && !rouse_s && !q.busy
            && q.armed) begin
          d.st = turns_pkg::ST_WAKE;
          d.armed = 1'b0;
          // parked pins hold select low, so drop the serial output with the pll
          d.miso_oe = 1'b0;
          d.pll_en = 1'b0;
          d.tristate = 1'b1;
          d.out_valid = 1'b0;
        end
      end
      turns_pkg::ST_WAKE: begin
        if (!all_low) begin
          d.st = turns_pkg::ST_LOCK;
          d.pll_en = 1'b1;
        end else if (period_end && !rouse_s && dmag < VELOCITY_THRESHOLD) begin
          d.st = turns_pkg::ST_SLEEP;
        end
        // otherwise stay awake while busy or roused
      end
      turns_pkg::ST_SLEEP: begin
        if (!all_low) begin
          d.st = turns_pkg::ST_LOCK;
          d.pll_en = 1'b1;
        end else if (period_end || rouse_s) begin
          d.st = turns_pkg::ST_WAKE;
          d.alive = q.alive + 16'h0001;
        end
      end
      turns_pkg::ST_LOCK: begin
        d.tristate = 1'b0;
        if (PLL_LOCKED) begin
          d.st = turns_pkg::ST_FULL;
          d.out_valid = 1'b1;
        end
      end
      default: begin
        d.st = turns_pkg::ST_INIT;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      q <= '0;
      q.st <= turns_pkg::ST_INIT;
      q.sync1 <= 4'h3;
      q.sync2 <= 4'h3;
      q.sclk_d <= 1'b1;
      q.miso <= 1'b1;
      q.total <= turns_pkg::TOTAL_RST;
      q.alive <= turns_pkg::ALIVE_RST;
    end else begin
      q <= d;
    end
  end

  assign LINK.miso_o = q.miso;
  assign LINK.miso_oe = q.miso_oe;
  assign PLL_ENABLE = q.pll_en;
  assign OUTPUTS_TRISTATE = q.tristate;
  assign ANGLE_OUTPUT_VALID = q.out_valid;
endmodule

// [turns_pkg.sv]
package turns_pkg;
  // ==========================================================
  // serial register map and frame layout
  localparam logic [6:0] REG_CTRL = 7'h1e;
  localparam logic [6:0] REG_TOTAL_HI = 7'h36;
  localparam logic [6:0] REG_TOTAL_LO = 7'h38;
  localparam logic [6:0] REG_ALIVE = 7'h3a;
  localparam logic [6:0] REG_FLAGS = 7'h3c;
  localparam int FRAME_BITS = 32;
  localparam int FRAME_WR_BIT = 31;
  localparam int FRAME_ADDR_LSB = 24;
  localparam logic [5:0] FRAME_HALF = 6'h10;
  localparam logic [5:0] FRAME_FULL = 6'h20;
  // special-action codes in control bits 3:0
  localparam logic [3:0] CMD_TURNS_RESET = 4'h1;
  localparam logic [3:0] CMD_LP_ARM = 4'h2;
  localparam logic [3:0] CMD_FLAG_CLEAR = 4'h3;
  // ==========================================================
  // angle arithmetic
  localparam logic [11:0] WARN_DELTA = 12'h600;
  localparam logic [12:0] REV45_MAX = 13'h07ff;
  localparam logic [12:0] REV45_MIN = 13'h1800;
  localparam logic [12:0] REV180_MAX = 13'h01ff;
  localparam logic [12:0] REV180_MIN = 13'h1e00;
  localparam logic [1:0] INIT_ZERO = 2'h0;
  localparam logic [1:0] INIT_ANGLE = 2'h1;
  localparam logic [23:0] TOTAL_RST = 24'h000000;
  localparam logic [15:0] ALIVE_RST = 16'h0000;
  // ==========================================================
  // timing
  localparam longint REF_CLK_HZ = 20000000;
  localparam longint LP_ENTRY_US = 64;
  localparam logic [11:0] LP_ENTRY_CYCLES =
    12'((LP_ENTRY_US * REF_CLK_HZ + 999999) / 1000000);
  localparam logic [3:0] SCLK_HALF_CYCLES = 4'h8;
  // ==========================================================
  // host command registers (wishbone byte offsets)
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_RDATA = 8'h04;
  localparam logic [7:0] HREG_STATUS = 8'h08;
  localparam logic [7:0] HREG_PINS = 8'h0c;
  // ==========================================================
  typedef enum logic [2:0] {ST_INIT, ST_FULL, ST_WAKE, ST_SLEEP, ST_LOCK} lp_state_t;
  typedef enum logic [0:0] {H_IDLE, H_RUN} host_state_t;
endpackage

// [turns_link_if.sv]
`timescale 1ns/10ps
interface turns_link_if;
  logic sclk;
  logic csn;
  logic mosi;
  logic rouse;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // released line is pulled high
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev (input sclk, input csn, input mosi, input rouse, output miso_o, output miso_oe);
  modport host (output sclk, output csn, output mosi, output rouse, input miso);
endinterface

// [sleep_timer.sv]
`timescale 1ns/10ps
module sleep_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // period in clock cycles, and end-of-period pulse
  input wire logic [W-1:0] period,
  output logic period_end
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tmr_t;
  tmr_t tmr_reg;
  tmr_t tmr_next;
  // free running whatever the state, so decisions align to fixed boundaries
  always_comb begin
    tmr_next = tmr_reg;
    tmr_next.tick = 1'b0;
    if (tmr_reg.cnt >= period - W'(1)) begin
      tmr_next.cnt = '0;
      tmr_next.tick = 1'b1;
    end else begin
      tmr_next.cnt = tmr_reg.cnt + W'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end
  assign period_end = tmr_reg.tick;
endmodule

// [turns_host.sv]
`timescale 1ns/10ps
module turns_host (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // link to device
  turns_link_if.host LINK
);
  typedef struct packed {
    turns_pkg::host_state_t st;
    logic [31:0] frame;
    logic [15:0] rx;
    logic [3:0] div;
    logic [5:0] bitcnt;
    logic sclk;
    logic csn;
    logic mosi;
    logic park;
    logic rouse;
    logic ack;
    logic [31:0] dat;
    logic ms1;
    logic ms2;
  } host_t;
  host_t q;
  host_t d;
  logic req;

  assign req = CYC_I && STB_I && !q.ack;

  // ==========================================================
  // command registers and serial master
  always_comb begin
    d = q;
    d.ms1 = LINK.miso;
    d.ms2 = q.ms1;
    d.ack = req;
    // register access, one wait state, ack dropped after one cycle
    if (req) begin
      if (ADR_I == turns_pkg::HREG_CMD) begin
        d.dat = q.frame;
        if (WE_I && SEL_I == 4'hf && q.st == turns_pkg::H_IDLE) begin
          d.frame = DAT_I; // writes while busy are dropped
          d.st = turns_pkg::H_RUN;
          d.div = 4'h0;
          d.bitcnt = 6'h00;
          d.csn = 1'b0;
          d.sclk = 1'b1;
          d.mosi = DAT_I[turns_pkg::FRAME_BITS - 1];
        end
      end else if (ADR_I == turns_pkg::HREG_RDATA) begin
        d.dat = {16'h0000, q.rx};
      end else if (ADR_I == turns_pkg::HREG_STATUS) begin
        d.dat = {31'h00000000, q.st == turns_pkg::H_RUN};
      end else if (ADR_I == turns_pkg::HREG_PINS) begin
        d.dat = {30'h00000000, q.rouse, q.park};
        if (WE_I && SEL_I[0]) begin
          d.park = DAT_I[0];
          d.rouse = DAT_I[1];
        end
      end else begin
        d.dat = 32'h00000000;
      end
    end
    case (q.st)
      turns_pkg::H_IDLE: begin
        // parking all pins low requests low power; leaving it resumes.
        // a frame starting this cycle keeps the select and data it was given
        if (d.st == turns_pkg::H_IDLE) begin
          d.csn = !d.park;
          d.sclk = !d.park;
          d.mosi = 1'b0;
        end
      end
      turns_pkg::H_RUN: begin
        d.div = q.div + 4'h1;
        if (q.div == turns_pkg::SCLK_HALF_CYCLES - 4'h1) begin
          d.div = 4'h0;
          if (q.bitcnt == turns_pkg::FRAME_FULL) begin
            d.st = turns_pkg::H_IDLE;
            d.csn = 1'b1;
            d.rx = q.frame[15:0];
          end else if (q.sclk) begin
            d.sclk = 1'b0;
            if (q.bitcnt != 6'h00) begin
              d.mosi = q.frame[31];
            end
          end else begin
            // rising edge: device samples mosi, host takes miso
            d.sclk = 1'b1;
            d.frame = {q.frame[30:0], q.ms2};
            d.bitcnt = q.bitcnt + 6'h01;
          end
        end
      end
      default: begin
        d.st = turns_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      q <= '0;
      q.st <= turns_pkg::H_IDLE;
      q.csn <= 1'b1;
      q.sclk <= 1'b1;
      q.ms1 <= 1'b1;
      q.ms2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign DAT_O = q.dat;
  assign ACK_O = q.ack;
  assign LINK.sclk = q.sclk;
  assign LINK.csn = q.csn;
  assign LINK.mosi = q.mosi;
  assign LINK.rouse = q.rouse;
endmodule

// [turns_link_asserts.sv]
`timescale 1ns/10ps
module turns_link_asserts (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // link pins
  input wire logic sclk,
  input wire logic csn,
  input wire logic mosi,
  input wire logic rouse,
  input wire logic miso_oe,
  // device power state
  input wire logic PLL_LOCKED,
  input wire logic PLL_ENABLE,
  input wire logic OUTPUTS_TRISTATE,
  input wire logic ANGLE_OUTPUT_VALID
);
  // ==========================================================
  // helper counters
  logic [15:0] low_cnt_reg;
  logic [5:0] rise_cnt_reg;
  logic sclk_reg;
  logic all_low;
  logic low_power;
  assign all_low = !sclk && !csn && !mosi;
  assign low_power = OUTPUTS_TRISTATE && !PLL_ENABLE;
  // raw pin counts; the device sees pins late, so its pins-low count never exceeds low_cnt_reg
  always_ff @(posedge REF_CLK) begin
    sclk_reg <= sclk;
    if (!RESETN || !all_low) begin
      low_cnt_reg <= 16'h0000;
    end else if (low_cnt_reg != 16'hffff) begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
    if (!RESETN || csn) begin
      rise_cnt_reg <= 6'h00;
    end else if (sclk && !sclk_reg) begin
      rise_cnt_reg <= rise_cnt_reg + 6'h01;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  sequence relock_s;
    ##[1:16] PLL_ENABLE;
  endsequence
  sequence entry_s;
    $fell(PLL_ENABLE) ##0 OUTPUTS_TRISTATE;
  endsequence
  entry_quiet_a: assert property ($fell(PLL_ENABLE) |->
    low_cnt_reg >= 16'(turns_pkg::LP_ENTRY_CYCLES) && !rouse)
    else $error("low power entered before pins were quiet long enough");
  entry_tristate_a: assert property ($fell(PLL_ENABLE) |-> entry_s)
    else $error("outputs not tristated on low power entry");
  lp_no_serial_a: assert property (low_power |-> !miso_oe)
    else $error("serial output driven in low power");
  lp_no_valid_a: assert property (!PLL_ENABLE |-> !ANGLE_OUTPUT_VALID)
    else $error("angle output valid without clock");
  valid_lock_a: assert property ($rose(ANGLE_OUTPUT_VALID) |->
    $past(PLL_LOCKED) && PLL_ENABLE)
    else $error("angle output resumed before lock");
  lp_hold_a: assert property (low_power && all_low |=> !PLL_ENABLE)
    else $error("low power left while pins stay low");
  lp_exit_a: assert property (low_power && $rose(csn) |-> relock_s)
    else $error("no relock after pins left the low state");
  csn_idle_a: assert property (csn |-> sclk)
    else $error("serial clock low while deselected");
  frame_bits_a: assert property ($rose(csn) && rise_cnt_reg > 6'h01 |->
    rise_cnt_reg == turns_pkg::FRAME_FULL)
    else $error("frame length wrong");
  oe_select_a: assert property ($rose(miso_oe) |-> !csn)
    else $error("serial output enabled while deselected");
endmodule

// [tb_low_power_turns_counter.sv]
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_low_power_turns_counter;
  // ==========================================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0] sel = 4'hf;
  logic [31:0] rdat;
  logic ack;
  logic [11:0] fine = 12'h123;
  logic [11:0] coarse = 12'h123;
  logic strobe = 1'b0;
  logic path_sel = 1'b1;
  logic [4:0] lock_cnt = 5'h00;
  logic pll_locked;
  logic pll_enable;
  logic tristate;
  logic out_valid;
  int miscompares = 0;
  int checks_done = 0;
  turns_link_if turns_link_if_i ();
  // free-running clock
  always #25 ref_clk = ~ref_clk;
  // simple pll: locks a while after enable, loses lock at once when disabled
  always @(posedge ref_clk) begin
    if (!pll_enable) lock_cnt <= 5'h00;
    else if (lock_cnt != 5'h10) lock_cnt <= lock_cnt + 5'h01;
  end
  assign pll_locked = (lock_cnt == 5'h10);
  // ==========================================================
  // design and checker
  turns_device turns_device_i (.REF_CLK(ref_clk), .RESETN(resetn), .LINK(turns_link_if_i),
    .FINE_ANGLE(fine), .COARSE_ANGLE(coarse), .ANGLE_STROBE(strobe),
    .COUNT_PATH_SELECT(path_sel), .MODE_180(1'b1), .TURNS_INIT(2'h1),
    .VELOCITY_THRESHOLD(12'h100), .SLEEP_PERIOD_SETTING(16'h0014),
    .PLL_LOCKED(pll_locked), .PLL_ENABLE(pll_enable), .OUTPUTS_TRISTATE(tristate),
    .ANGLE_OUTPUT_VALID(out_valid));
  turns_host turns_host_i (.REF_CLK(ref_clk), .RESETN(resetn), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel), .DAT_O(rdat), .ACK_O(ack),
    .LINK(turns_link_if_i));
  turns_link_asserts turns_link_asserts_i (.REF_CLK(ref_clk), .RESETN(resetn),
    .sclk(turns_link_if_i.sclk), .csn(turns_link_if_i.csn), .mosi(turns_link_if_i.mosi),
    .rouse(turns_link_if_i.rouse), .miso_oe(turns_link_if_i.miso_oe),
    .PLL_LOCKED(pll_locked), .PLL_ENABLE(pll_enable), .OUTPUTS_TRISTATE(tristate),
    .ANGLE_OUTPUT_VALID(out_valid));
  // ==========================================================
  // common tasks
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    $display("mismatch wait_bound expected done seen hang");
    finish_test();
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) hang();
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  // a serial frame through the host, polled until the link is idle again
  task automatic frame(input logic w, input logic [6:0] a, input logic [15:0] d,
                       output logic [15:0] r);
    logic [31:0] x;
    int n;
    n = 0;
    wb(1'b1, turns_pkg::HREG_CMD, {w, a, 8'h00, d}, x);
    do begin
      wb(1'b0, turns_pkg::HREG_STATUS, 32'h0, x);
      n++;
    end while (x[0] !== 1'b0 && n < 400);
    if (x[0] !== 1'b0) hang();
    wb(1'b0, turns_pkg::HREG_RDATA, 32'h0, x);
    r = x[15:0];
  endtask
  task automatic total(output logic [23:0] t);
    logic [15:0] h;
    logic [15:0] l;
    frame(1'b0, turns_pkg::REG_TOTAL_HI, 16'h0, h);
    frame(1'b0, turns_pkg::REG_TOTAL_LO, 16'h0, l);
    t = {h[11:0], l[11:0]};
  endtask
  task automatic cmd(input logic [3:0] c);
    logic [15:0] r;
    frame(1'b1, turns_pkg::REG_CTRL, {12'h000, c}, r);
  endtask
  task automatic step(input logic [11:0] df, input logic [11:0] dc);
    fine <= fine + df;
    coarse <= coarse + dc;
    strobe <= 1'b1;
    @(posedge ref_clk);
    strobe <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_valid(input logic v);
    int n;
    n = 0;
    while (out_valid !== v && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    if (out_valid !== v) hang();
  endtask
  // ==========================================================
  // scenarios
  task automatic t_startup();
    logic [31:0] r;
    logic [23:0] t;
    wb(1'b0, 8'h10, 32'h0, r);
    `CHK("unmapped", 32'h0, r);
    // a command write without all byte lanes must not start a frame
    sel <= 4'h1;
    wb(1'b1, turns_pkg::HREG_CMD, 32'h0, r);
    sel <= 4'hf;
    wb(1'b0, turns_pkg::HREG_STATUS, 32'h0, r);
    `CHK("cmd_sel_refused", 32'h0, r);
    total(t);
    `CHK("total_init", 24'h000123, t);
  endtask
  task automatic t_full_path();
    logic [23:0] t;
    logic [15:0] h;
    logic [15:0] l;
    cmd(turns_pkg::CMD_TURNS_RESET);
    total(t);
    `CHK("total_reset", 24'h000000, t);
    step(12'he00, 12'h000);
    step(12'he00, 12'h000);
    total(t);
    `CHK("total_neg", 24'hfffc00, t);
    frame(1'b0, turns_pkg::REG_TOTAL_HI, 16'h0, h);
    step(12'h100, 12'h000);
    frame(1'b0, turns_pkg::REG_TOTAL_LO, 16'h0, l);
    `CHK("lower_frozen", 24'hfffc00, {h[11:0], l[11:0]});
    coarse <= fine;
  endtask
  task automatic t_coarse_path();
    logic [23:0] t;
    path_sel <= 1'b0;
    cmd(turns_pkg::CMD_TURNS_RESET);
    step(12'h300, 12'h100);
    total(t);
    `CHK("total_coarse", 24'h000100, t);
  endtask
  task automatic t_saturate();
    logic [23:0] t;
    logic [15:0] f;
    cmd(turns_pkg::CMD_TURNS_RESET);
    repeat (1030) step(12'h7ff, 12'h7ff);
    total(t);
    `CHK("revs_sat", 12'h1ff, t[23:12]);
    frame(1'b0, turns_pkg::REG_FLAGS, 16'h0, f);
    `CHK("ovf_set", 1'b1, f[0]);
    cmd(turns_pkg::CMD_TURNS_RESET);
    frame(1'b0, turns_pkg::REG_FLAGS, 16'h0, f);
    `CHK("ovf_clear", 1'b0, f[0]);
  endtask
  task automatic t_low_power();
    logic [31:0] r;
    logic [15:0] a0;
    logic [15:0] a1;
    logic [15:0] f;
    logic [23:0] t;
    // a calm sample first, so only the missing arm command can block entry
    step(12'h000, 12'h000);
    wb(1'b1, turns_pkg::HREG_PINS, 32'h1, r);
    repeat (1600) @(posedge ref_clk);
    `CHK("no_entry_unarmed", 1'b1, out_valid);
    wb(1'b1, turns_pkg::HREG_PINS, 32'h0, r);
    repeat (20) @(posedge ref_clk);
    frame(1'b0, turns_pkg::REG_ALIVE, 16'h0, a0);
    cmd(turns_pkg::CMD_LP_ARM);
    wb(1'b1, turns_pkg::HREG_PINS, 32'h1, r);
    wait_valid(1'b0);
    `CHK("lp_tristate", 2'b10, {tristate, pll_enable});
    coarse <= coarse + 12'h700;
    repeat (200) @(posedge ref_clk);
    wb(1'b1, turns_pkg::HREG_PINS, 32'h3, r);
    repeat (100) @(posedge ref_clk);
    wb(1'b1, turns_pkg::HREG_PINS, 32'h1, r);
    coarse <= coarse + 12'h900;
    repeat (200) @(posedge ref_clk);
    wb(1'b1, turns_pkg::HREG_PINS, 32'h0, r);
    wait_valid(1'b1);
    total(t);
    `CHK("lp_total", 24'h000000, t);
    frame(1'b0, turns_pkg::REG_FLAGS, 16'h0, f);
    `CHK("warn_armed", 2'b01, f[2:1]);
    frame(1'b0, turns_pkg::REG_ALIVE, 16'h0, a1);
    `CHK("alive_moved", 1'b1, a1 != a0);
    cmd(turns_pkg::CMD_FLAG_CLEAR);
    frame(1'b0, turns_pkg::REG_FLAGS, 16'h0, f);
    `CHK("warn_clear", 1'b0, f[1]);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    wait_valid(1'b1);
    t_startup();
    t_full_path();
    t_coarse_path();
    t_saturate();
    t_low_power();
    finish_test();
  end
endmodule
